// ---- rtl/lpw_regs.vh ----
// Constants for the low-power mode wakeup controller
`ifndef LPW_REGS_VH
`define LPW_REGS_VH

// ----------------------------------------------------------------
// Power states
// ----------------------------------------------------------------
`define LPW_ST_RUN      3'h0
`define LPW_ST_STOP     3'h1
`define LPW_ST_STANDBY  3'h2
`define LPW_ST_BATTERY  3'h3
`define LPW_ST_WAKE     3'h4

// ----------------------------------------------------------------
// Event vector layout
// ----------------------------------------------------------------
`define LPW_EXT_LINES   16
`define LPW_EV_W        22
`define LPW_EV_SUPPLY   16
`define LPW_EV_RTC_ALM  17
`define LPW_EV_RTC_WKP  18
`define LPW_EV_RTC_TAMP 19
`define LPW_EV_RTC_TS   20
`define LPW_EV_USB      21
`define LPW_EV_ETH      22

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LPW_CLK_NS      10
`define LPW_WAKE_NS     100
`define LPW_WAKE_CYC    (((`LPW_WAKE_NS) + (`LPW_CLK_NS) - 1) / (`LPW_CLK_NS))

`endif

// ---- rtl/lpw_edge_det.v ----
// Per-bit rising edge detector for wakeup event inputs
`timescale 1ns/10ps
`default_nettype none

module lpw_edge_det #(
  parameter W = 8
) (
  input  wire         clk_sys_in,
  input  wire         reset_n_in,
  input  wire         clk_en_in,
  input  wire [W-1:0] level_in,
  output wire [W-1:0] rise_out
);

  reg [W-1:0] prev_q;

  // ----------------------------------------------------------------
  // One flop per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          prev_q[i] <= 1'b0;
        end else if (clk_en_in) begin
          prev_q[i] <= level_in[i];
        end
      end
      assign rise_out[i] = level_in[i] & ~prev_q[i];
    end
  endgenerate

endmodule // lpw_edge_det

`default_nettype wire

// ---- rtl/lpw_ctrl.v ----
// Low-power mode entry and wakeup controller
`timescale 1ns/10ps
`default_nettype none
`include "lpw_regs.vh"

module lpw_ctrl (
  input  wire                       clk_sys_in,
  input  wire                       reset_n_in,
  input  wire                       clk_en_in,
  input  wire                       main_supply_ok_in,
  input  wire                       stop_req_in,
  input  wire                       standby_req_in,
  input  wire                       stop_reg_lp_in,
  input  wire                       backup_sram_keep_in,
  input  wire [`LPW_EXT_LINES-1:0]  external_event_lines_in,
  input  wire                       supply_threshold_detector_in,
  input  wire                       rtc_alarm_in,
  input  wire                       rtc_wakeup_in,
  input  wire                       rtc_tamper_in,
  input  wire                       rtc_timestamp_in,
  input  wire                       usb_wakeup_in,
  input  wire                       eth_wakeup_in,
  input  wire                       external_reset_pin_n_in,
  input  wire                       independent_watchdog_rst_in,
  input  wire                       wakeup_pin_in,
  output reg  [2:0]                 power_state_out,
  output reg                        core_run_out,
  output reg                        core_domain_pwr_out,
  output reg                        regulator_on_out,
  output reg                        regulator_lp_out,
  output reg                        pll_en_out,
  output reg                        internal_rc_oscillator_en_out,
  output reg                        external_crystal_oscillator_en_out,
  output reg                        sram_retain_out,
  output reg                        backup_domain_pwr_out,
  output reg                        backup_sram_pwr_out,
  output reg                        rtc_run_out,
  output reg                        independent_watchdog_run_out,
  output reg                        system_reset_out,
  output reg                        wakeup_out
);

  // ----------------------------------------------------------------
  // Event gathering
  // ----------------------------------------------------------------
  wire [`LPW_EV_W:0] ev_level;
  wire [`LPW_EV_W:0] ev_rise;
  wire [3:0]         pin_level;
  wire [3:0]         pin_rise;

  assign ev_level = {eth_wakeup_in, usb_wakeup_in, rtc_timestamp_in, rtc_tamper_in,
                     rtc_wakeup_in, rtc_alarm_in, supply_threshold_detector_in,
                     external_event_lines_in};
  assign pin_level = {wakeup_pin_in, independent_watchdog_rst_in,
                      ~external_reset_pin_n_in, 1'b0};

  // Edge detection keeps an event or wakeup pin level held before entry from waking at once; reset pin and watchdog reset wake Standby on level
  lpw_edge_det #(
    .W (`LPW_EV_W + 1 + 4)
  ) u_edge (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .level_in   ({pin_level, ev_level}),
    .rise_out   ({pin_rise, ev_rise})
  );

  wire stop_wake = |ev_rise;
  wire rtc_any   = ev_rise[`LPW_EV_RTC_ALM] | ev_rise[`LPW_EV_RTC_WKP] |
                   ev_rise[`LPW_EV_RTC_TAMP] | ev_rise[`LPW_EV_RTC_TS];
  wire reset_evt = ~external_reset_pin_n_in | independent_watchdog_rst_in;
  wire stby_wake = reset_evt | pin_rise[3] | rtc_any;

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [3:0] wake_cnt_q;
  reg [3:0] wake_cnt_d;
  reg       bsram_sel_q;
  reg       reg_lp_q;
  reg       from_stby_q;
  reg       from_stby_d;

  always @* begin
    state_d     = state_q;
    wake_cnt_d  = wake_cnt_q;
    from_stby_d = from_stby_q;
    if (!main_supply_ok_in) begin
      state_d = `LPW_ST_BATTERY;
    end else begin
      case (state_q)
        `LPW_ST_RUN: begin
          if (standby_req_in) begin
            state_d = `LPW_ST_STANDBY;
          end else if (stop_req_in) begin
            state_d = `LPW_ST_STOP;
          end
        end
        `LPW_ST_STOP: begin
          if (stop_wake) begin
            state_d     = `LPW_ST_WAKE;
            wake_cnt_d  = 4'h0;
            from_stby_d = 1'b0;
          end
        end
        `LPW_ST_STANDBY: begin
          if (stby_wake) begin
            state_d     = `LPW_ST_WAKE;
            wake_cnt_d  = 4'h0;
            from_stby_d = 1'b1;
          end
        end
        `LPW_ST_BATTERY: begin
          // Only the return of main supply leaves, never an event
          state_d     = `LPW_ST_WAKE;
          wake_cnt_d  = 4'h0;
          from_stby_d = 1'b1;
        end
        `LPW_ST_WAKE: begin
          if (wake_cnt_q == (`LPW_WAKE_CYC - 1)) begin
            state_d = `LPW_ST_RUN;
          end else begin
            wake_cnt_d = wake_cnt_q + 4'h1;
          end
        end
        default: begin
          state_d = `LPW_ST_RUN;
        end
      endcase
    end
  end

  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q     <= `LPW_ST_RUN;
      wake_cnt_q  <= 4'h0;
      from_stby_q <= 1'b0;
      bsram_sel_q <= 1'b0;
      reg_lp_q    <= 1'b0;
    end else if (clk_en_in) begin
      state_q     <= state_d;
      wake_cnt_q  <= wake_cnt_d;
      from_stby_q <= from_stby_d;
      // Choices latched at entry so they hold while the core is off
      if (state_q == `LPW_ST_RUN) begin
        bsram_sel_q <= backup_sram_keep_in;
        reg_lp_q    <= stop_reg_lp_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power controls, registered
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      power_state_out                    <= `LPW_ST_RUN;
      core_run_out                       <= 1'b1;
      core_domain_pwr_out                <= 1'b1;
      regulator_on_out                   <= 1'b1;
      regulator_lp_out                   <= 1'b0;
      pll_en_out                         <= 1'b1;
      internal_rc_oscillator_en_out      <= 1'b1;
      external_crystal_oscillator_en_out <= 1'b1;
      sram_retain_out                    <= 1'b1;
      backup_domain_pwr_out              <= 1'b1;
      backup_sram_pwr_out                <= 1'b1;
      rtc_run_out                        <= 1'b1;
      independent_watchdog_run_out       <= 1'b1;
      system_reset_out                   <= 1'b0;
      wakeup_out                         <= 1'b0;
    end else if (clk_en_in) begin
      power_state_out <= state_d;
      core_run_out    <= (state_d == `LPW_ST_RUN);
      case (state_d)
        `LPW_ST_STOP: begin
          core_domain_pwr_out                <= 1'b1;
          regulator_on_out                   <= 1'b1;
          // Entry edge takes the live choice; later cycles keep the latched one
          regulator_lp_out                   <= (state_q == `LPW_ST_RUN) ?
                                                stop_reg_lp_in : reg_lp_q;
          pll_en_out                         <= 1'b0;
          internal_rc_oscillator_en_out      <= 1'b0;
          external_crystal_oscillator_en_out <= 1'b0;
          sram_retain_out                    <= 1'b1;
          backup_sram_pwr_out                <= 1'b1;
          independent_watchdog_run_out       <= 1'b1;
        end
        `LPW_ST_STANDBY: begin
          core_domain_pwr_out                <= 1'b0;
          regulator_on_out                   <= 1'b0;
          regulator_lp_out                   <= 1'b0;
          pll_en_out                         <= 1'b0;
          internal_rc_oscillator_en_out      <= 1'b0;
          external_crystal_oscillator_en_out <= 1'b0;
          sram_retain_out                    <= 1'b0;
          backup_sram_pwr_out                <= (state_q == `LPW_ST_RUN) ?
                                                backup_sram_keep_in : bsram_sel_q;
          independent_watchdog_run_out       <= 1'b1;
        end
        `LPW_ST_BATTERY: begin
          core_domain_pwr_out                <= 1'b0;
          regulator_on_out                   <= 1'b0;
          regulator_lp_out                   <= 1'b0;
          pll_en_out                         <= 1'b0;
          internal_rc_oscillator_en_out      <= 1'b0;
          external_crystal_oscillator_en_out <= 1'b0;
          sram_retain_out                    <= 1'b0;
          backup_sram_pwr_out                <= 1'b1;
          independent_watchdog_run_out       <= 1'b0;
        end
        default: begin
          core_domain_pwr_out                <= 1'b1;
          regulator_on_out                   <= 1'b1;
          regulator_lp_out                   <= 1'b0;
          pll_en_out                         <= 1'b1;
          internal_rc_oscillator_en_out      <= 1'b1;
          external_crystal_oscillator_en_out <= 1'b1;
          sram_retain_out                    <= 1'b1;
          backup_sram_pwr_out                <= 1'b1;
          independent_watchdog_run_out       <= 1'b1;
        end
      endcase
      // Backup domain and RTC never lose power in any state
      backup_domain_pwr_out <= 1'b1;
      rtc_run_out           <= 1'b1;
      // Leaving Standby or battery restarts the core from reset
      system_reset_out <= (state_d == `LPW_ST_WAKE) & from_stby_d;
      wakeup_out       <= (state_d == `LPW_ST_WAKE) & (state_q != `LPW_ST_WAKE);
    end
  end

endmodule // lpw_ctrl

`default_nettype wire

// ---- test/lpw_ctrl_asserts.sv ----
// Assertion checker for the low-power mode wakeup controller
`timescale 1ns/10ps
`default_nettype none
`include "lpw_regs.vh"
module lpw_ctrl_asserts (
  input wire logic        clk_sys_in,
  input wire logic        reset_n_in,
  input wire logic        clk_en_in,
  input wire logic        main_supply_ok_in,
  input wire logic        stop_req_in,
  input wire logic        standby_req_in,
  input wire logic        stop_reg_lp_in,
  input wire logic [15:0] external_event_lines_in,
  input wire logic        external_reset_pin_n_in,
  input wire logic [2:0]  power_state_out,
  input wire logic        core_domain_pwr_out,
  input wire logic        regulator_on_out,
  input wire logic        regulator_lp_out,
  input wire logic        pll_en_out,
  input wire logic        internal_rc_oscillator_en_out,
  input wire logic        external_crystal_oscillator_en_out,
  input wire logic        sram_retain_out,
  input wire logic        backup_domain_pwr_out,
  input wire logic        backup_sram_pwr_out,
  input wire logic        rtc_run_out,
  input wire logic        independent_watchdog_run_out,
  input wire logic        system_reset_out,
  input wire logic        wakeup_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  wire logic go  = clk_en_in && main_supply_ok_in;
  wire logic stp = power_state_out == `LPW_ST_STOP;
  wire logic sby = power_state_out == `LPW_ST_STANDBY;
  wire logic bat = power_state_out == `LPW_ST_BATTERY;
  wire logic osc = pll_en_out | internal_rc_oscillator_en_out | external_crystal_oscillator_en_out;
  // Regulator mode is captured on the entry edge, not while stopped
  chk_stop_entry_mode:
    assert property (power_state_out == `LPW_ST_RUN && go && stop_req_in && !standby_req_in
      |=> stp && regulator_on_out && regulator_lp_out == $past(stop_reg_lp_in))
      else $error("stop entry or regulator mode wrong");
  chk_stop_line_wake:
    assert property (stp && go && $past(clk_en_in)
      && |(external_event_lines_in & ~$past(external_event_lines_in))
      |=> power_state_out == `LPW_ST_WAKE && wakeup_out)
      else $error("external line did not wake stop");
  chk_wake_pulse_once:
    assert property (wakeup_out && clk_en_in |-> power_state_out == `LPW_ST_WAKE ##1 !wakeup_out)
      else $error("wakeup pulse malformed");
  chk_standby_power_off:
    assert property (sby |-> !regulator_on_out && !core_domain_pwr_out && !osc)
      else $error("standby left power or clocks on");
  chk_standby_retention:
    assert property (sby |-> !sram_retain_out && backup_domain_pwr_out)
      else $error("standby retention wrong");
  chk_standby_pin_exit:
    assert property (sby && go && !external_reset_pin_n_in
      |=> power_state_out == `LPW_ST_WAKE && system_reset_out)
      else $error("reset pin did not leave standby");
  chk_lowpower_timers_run:
    assert property (stp || sby |-> rtc_run_out && independent_watchdog_run_out)
      else $error("timers stopped in low power");
  chk_battery_entry:
    assert property (clk_en_in && !main_supply_ok_in |=> bat)
      else $error("no battery state without supply");
  chk_battery_domain:
    assert property (bat |-> rtc_run_out && backup_domain_pwr_out && backup_sram_pwr_out
      && !core_domain_pwr_out && !sram_retain_out && !osc)
      else $error("battery power domains wrong");
  chk_battery_hold:
    assert property (bat && !main_supply_ok_in |=> bat && !wakeup_out)
      else $error("battery state left while unpowered");
  cover property (stp ##1 power_state_out == `LPW_ST_WAKE);
  cover property (sby ##1 system_reset_out);
  cover property (bat ##1 !bat);
endmodule // lpw_ctrl_asserts
bind lpw_ctrl lpw_ctrl_asserts u_chk (.*);
`default_nettype wire

// ---- test/lpw_far_model.sv ----
// Far-side model holding the wakeup sources seen by the controller
`timescale 1ns/10ps
`default_nettype none
module lpw_far_model (
  output wire logic [24:0] ev_out,
  output wire logic        rst_pin_n_out
);
  // Bit 25 is the reset pin, kept active high here for one-hot use
  logic [25:0] src_q = 26'h0000000;
  assign ev_out        = src_q[24:0];
  assign rst_pin_n_out = ~src_q[25];
  task automatic set_src(input logic [25:0] v);
    src_q = v;
  endtask
endmodule // lpw_far_model
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking testbench for the low-power mode wakeup controller
`timescale 1ns/10ps
`default_nettype none
`include "lpw_regs.vh"
module testbench;
  logic clk_sys_in, reset_n_in, clk_en_in, main_supply_ok_in;
  logic stop_req_in, standby_req_in, stop_reg_lp_in, backup_sram_keep_in;
  wire logic [24:0] ev;
  wire logic [15:0] external_event_lines_in;
  wire logic supply_threshold_detector_in, rtc_alarm_in, rtc_wakeup_in, rtc_tamper_in;
  wire logic rtc_timestamp_in, usb_wakeup_in, eth_wakeup_in, external_reset_pin_n_in;
  wire logic independent_watchdog_rst_in, wakeup_pin_in, core_run_out, regulator_lp_out;
  wire logic [2:0] power_state_out;
  wire logic core_domain_pwr_out, regulator_on_out, pll_en_out, sram_retain_out;
  wire logic internal_rc_oscillator_en_out, external_crystal_oscillator_en_out;
  wire logic backup_domain_pwr_out, backup_sram_pwr_out, rtc_run_out, system_reset_out;
  wire logic independent_watchdog_run_out, wakeup_out;
  wire logic osc = pll_en_out | internal_rc_oscillator_en_out | external_crystal_oscillator_en_out;
  int fails = 0;
  int total_checks = 0;
  assign {wakeup_pin_in, independent_watchdog_rst_in, eth_wakeup_in, usb_wakeup_in,
          rtc_timestamp_in, rtc_tamper_in, rtc_wakeup_in, rtc_alarm_in,
          supply_threshold_detector_in, external_event_lines_in} = ev;
  lpw_far_model far (.ev_out(ev), .rst_pin_n_out(external_reset_pin_n_in));
  lpw_ctrl uut (.*);
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic back_to_run;
    far.set_src(26'h0000000);
    tick(10);
    check(power_state_out === `LPW_ST_RUN && core_run_out === 1'b1, "not back in run");
  endtask
  // Every stop source, first one delayed by a frozen clock enable
  task automatic t_stop_wake;
    for (int k = 0; k < 23; k++) begin
      stop_reg_lp_in = k[0];
      stop_req_in = 1'b1;
      tick(1);
      stop_req_in = 1'b0;
      check(power_state_out === `LPW_ST_STOP && regulator_lp_out === k[0], "stop mode");
      check(osc === 1'b0 && rtc_run_out === 1'b1 && independent_watchdog_run_out === 1'b1, "stop clk");
      far.set_src(26'h0000001 << k);
      clk_en_in = (k != 0);
      tick(1);
      if (k == 0) begin
        check(power_state_out === `LPW_ST_STOP, "woke while frozen");
        clk_en_in = 1'b1;
        tick(1);
      end
      check(power_state_out === `LPW_ST_WAKE && wakeup_out === 1'b1, "stop source ignored");
      back_to_run();
    end
  endtask
  task automatic t_standby;
    int src [7] = '{25, 23, 24, 17, 18, 19, 20};
    for (int i = 0; i < 7; i++) begin
      backup_sram_keep_in = i[0];
      standby_req_in = 1'b1;
      stop_req_in = 1'b1;
      tick(1);
      standby_req_in = 1'b0;
      stop_req_in = 1'b0;
      check(power_state_out === `LPW_ST_STANDBY && !regulator_on_out && !core_domain_pwr_out
            && osc === 1'b0, "standby power");
      check(!sram_retain_out && backup_domain_pwr_out && backup_sram_pwr_out === i[0], "retain");
      far.set_src(26'h0000001);
      tick(1);
      check(power_state_out === `LPW_ST_STANDBY, "line woke standby");
      far.set_src(26'h0000001 << src[i]);
      tick(1);
      check(power_state_out === `LPW_ST_WAKE && system_reset_out === 1'b1, "no exit");
      back_to_run();
    end
  endtask
  // Supply lost while stopped; events must not leave battery state
  task automatic t_battery;
    stop_req_in = 1'b1;
    tick(1);
    stop_req_in = 1'b0;
    main_supply_ok_in = 1'b0;
    tick(1);
    check(power_state_out === `LPW_ST_BATTERY, "no battery state");
    check(rtc_run_out && backup_domain_pwr_out && backup_sram_pwr_out && !core_domain_pwr_out
          && !sram_retain_out && osc === 1'b0 && independent_watchdog_run_out === 1'b0,
          "battery domains");
    far.set_src(26'h01E0001);
    tick(2);
    check(power_state_out === `LPW_ST_BATTERY && wakeup_out === 1'b0, "left battery");
    main_supply_ok_in = 1'b1;
    tick(1);
    check(power_state_out === `LPW_ST_WAKE, "no wake on supply");
    back_to_run();
  endtask
  task automatic close_out;
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    reset_n_in = 1'b0;
    clk_en_in = 1'b1;
    main_supply_ok_in = 1'b1;
    stop_req_in = 1'b0;
    standby_req_in = 1'b0;
    stop_reg_lp_in = 1'b0;
    backup_sram_keep_in = 1'b0;
    tick(3);
    reset_n_in = 1'b1;
    check(power_state_out === `LPW_ST_RUN && regulator_lp_out === 1'b0, "reset state");
    t_stop_wake();
    t_standby();
    t_battery();
    close_out();
  end
  // About 390 cycles expected, some thirteen times that allowed
  initial begin
    #50000;
    fails++;
    close_out();
  end
endmodule // testbench
`default_nettype wire
